// *** bridge_window_params.svh ***
/*
 * Constants for the downstream window register bank: register offsets,
 * field positions, fixed field values and reset values.
 * Assumes it is included by bare name wherever these names are needed.
 */
`ifndef BRIDGE_WINDOW_PARAMS_SVH
`define BRIDGE_WINDOW_PARAMS_SVH

// Register byte offsets on the APB.
`define OFS_BUS_LAT        12'h018
`define OFS_IO_STS         12'h01c
`define OFS_MEM_WIN        12'h020
`define OFS_IO_UPPER       12'h030
`define OFS_EVT_CTRL       12'h03c

// Field positions at offset 0x18.
`define LAT_TIMER_FLD      31:24
`define LAT_TIMER_VAL      8'h00

// Field positions at offset 0x1C.
`define IO_BASE_IND_FLD    3:0
`define IO_BASE_FLD        7:4
`define IO_LIM_IND_FLD     11:8
`define IO_LIM_FLD         15:12
`define IO_IND_VAL         4'h1
`define IO_FLD_RST         4'h0
`define STS_FLD            31:16
`define STS_PARITY_BIT     24
`define STS_SIG_ABORT_BIT  27
`define STS_RX_ABORT_BIT   28
`define STS_RX_UR_BIT      29
`define STS_SYS_ERR_BIT    30
`define STS_POISON_BIT     31
`define STS_W1C_MASK       6'h31
`define STS_RST            6'h00

// Field positions at offset 0x20.
`define MEM_BASE_FLD       15:4
`define MEM_LIM_FLD        31:20
`define MEM_FLD_RST        12'h000

// Field positions at offset 0x30.
`define IO_UP_BASE_FLD     15:0
`define IO_UP_LIM_FLD      31:16
`define IO_UP_RST          16'h0000

// Field positions at offset 0x3C.
`define CTRL_PERR_EN_BIT   0
`define CTRL_SYS_ERR_EN_BIT 1

// Implied low address bits of the windows.
`define IO_LOW_ZERO        12'h000
`define IO_LOW_ONES        12'hfff
`define MEM_LOW_ZERO       20'h0_0000
`define MEM_LOW_ONES       20'hf_ffff

`define WORD_ZERO          32'h0000_0000

`endif

// *** bridge_window_pkg.sv ***
/*
 * Types shared by the window register bank and its window decoder.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package bridge_window_pkg;

    typedef logic [31:0] word_t;
    typedef logic [11:0] apb_addr_t;
    typedef logic [3:0]  byte_en_t;

    // Register selected by an APB address.
    typedef enum logic [2:0] {
        SEL_NONE    = 3'b000,
        SEL_BUS_LAT = 3'b001,
        SEL_IO_STS  = 3'b010,
        SEL_MEM_WIN = 3'b011,
        SEL_IO_UP   = 3'b100,
        SEL_CTRL    = 3'b101
    } reg_sel_t;

    // Index of each sticky downstream event within the status vector.
    typedef enum logic [2:0] {
        EVT_PARITY    = 3'b000,
        EVT_SIG_ABORT = 3'b001,
        EVT_RX_ABORT  = 3'b010,
        EVT_RX_UR     = 3'b011,
        EVT_SYS_ERR   = 3'b100,
        EVT_POISON    = 3'b101
    } evt_idx_t;

endpackage : bridge_window_pkg

`default_nettype wire

// *** window_match_if.sv ***
/*
 * Carries the decoded window bounds and one address query from the
 * register bank to the window decoder, and the hit answer back.
 * Assumes both ends sit on the same clock; the answer is combinational.
 */
`timescale 1ns/1ps
`default_nettype none

interface window_match_if;
    import bridge_window_pkg::*;

    word_t io_lo;
    word_t io_hi;
    word_t mem_lo;
    word_t mem_hi;
    word_t addr;
    logic  is_io;
    logic  hit;

    modport bank
    (
        output io_lo,
        output io_hi,
        output mem_lo,
        output mem_hi,
        output addr,
        output is_io,
        input  hit
    );

    modport decoder
    (
        input  io_lo,
        input  io_hi,
        input  mem_lo,
        input  mem_hi,
        input  addr,
        input  is_io,
        output hit
    );
endinterface : window_match_if

`default_nettype wire

// *** window_decode.sv ***
/*
 * Compares a transaction address with the I/O or the memory window and
 * reports whether it falls inside, both bounds inclusive.
 * Assumes the bounds arrive already widened with their implied low bits.
 */
`timescale 1ns/1ps
`default_nettype none

module window_decode
(
    window_match_if.decoder win
);
    import bridge_window_pkg::*;

    logic io_in;
    logic mem_in;

    // An empty window (base above limit) never matches.
    always_comb
    begin
        io_in   = (win.addr >= win.io_lo) && (win.addr <= win.io_hi);
        mem_in  = (win.addr >= win.mem_lo) && (win.addr <= win.mem_hi);
        win.hit = win.is_io ? io_in : mem_in;
    end

endmodule : window_decode

`default_nettype wire

// *** bridge_secondary_window_regs.sv ***
/*
 * Downstream window register bank of a bridge configuration header,
 * reached over APB, with sticky downstream event status and a one-cycle
 * forwarding decision for I/O and memory transactions.
 * Assumes event inputs are one-cycle pulses from logic on pclk.
 */
// The implementer's own choice: the APB slave port.

// Behaviour
// - Latency timer byte reads zero, ignores writes.
// - Both I/O low nibbles read fixed one.
// - I/O base bits 15:12 writable, low zero.
// - I/O limit bits 15:12 writable, low ones.
// - I/O upper address halves from separate register.
// - I/O window decides I/O forwarding.
// - Parity status sets only when response enabled.
// - Completer abort sent sets status bit 27.
// - Received completer abort sets status bit 28.
// - Received unsupported request sets bit 29.
// - Error message with reporting enabled sets 30.
// - Poisoned packet received sets status bit 31.
// - Inapplicable and reserved status bits read zero.
// - Memory base bits 31:20 writable, low zero.
// - Memory window decides memory forwarding.
// - Memory limit bits 31:20 writable, low ones.
// - I/O upper base halfword writable at 0x30.
`timescale 1ns/1ps
`default_nettype none
`include "bridge_window_params.svh"

module bridge_secondary_window_regs
(
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire bridge_window_pkg::apb_addr_t paddr,
    input  wire bridge_window_pkg::word_t     pwdata,
    input  wire bridge_window_pkg::byte_en_t  pstrb,
    output var  bridge_window_pkg::word_t     prdata,
    output var  logic                         pready,
    output var  logic                         pslverr,
    input  wire logic                         parity_err_evt,
    input  wire logic                         cpl_abort_sent_evt,
    input  wire logic                         rx_cpl_abort_evt,
    input  wire logic                         rx_cpl_ur_evt,
    input  wire logic                         err_msg_sent_evt,
    input  wire logic                         poisoned_rx_evt,
    input  wire logic                         fwd_req,
    input  wire bridge_window_pkg::word_t     fwd_addr,
    input  wire logic                         fwd_is_io,
    output var  logic                         fwd_valid,
    output var  logic                         fwd_hit
);
    import bridge_window_pkg::*;

    // Maps an APB address onto the register it selects.
    function automatic reg_sel_t addr_decode(input apb_addr_t a);
        reg_sel_t s;
        unique case (a)
            `OFS_BUS_LAT:  s = SEL_BUS_LAT;
            `OFS_IO_STS:   s = SEL_IO_STS;
            `OFS_MEM_WIN:  s = SEL_MEM_WIN;
            `OFS_IO_UPPER: s = SEL_IO_UP;
            `OFS_EVT_CTRL: s = SEL_CTRL;
            default:       s = SEL_NONE;
        endcase
        return s;
    endfunction : addr_decode

    // Replaces the bits of old that the byte mask selects.
    function automatic word_t merge(input word_t old, input word_t wd, input word_t m);
        return (old & ~m) | (wd & m);
    endfunction : merge

    logic [3:0]  io_base_r;
    logic [3:0]  io_base_nxt;
    logic [3:0]  io_lim_r;
    logic [3:0]  io_lim_nxt;
    logic [11:0] mem_base_r;
    logic [11:0] mem_base_nxt;
    logic [11:0] mem_lim_r;
    logic [11:0] mem_lim_nxt;
    logic [15:0] io_up_base_r;
    logic [15:0] io_up_base_nxt;
    logic [15:0] io_up_lim_r;
    logic [15:0] io_up_lim_nxt;
    logic        perr_resp_en_r;
    logic        perr_resp_en_nxt;
    logic        system_error_report_enable_r;
    logic        system_error_report_enable_nxt;
    logic [5:0]  status_r;
    logic [5:0]  status_nxt;
    logic [5:0]  evt_set;
    logic [5:0]  evt_clr;
    word_t       prdata_r;
    word_t       prdata_nxt;
    logic        pready_r;
    logic        pready_nxt;
    logic        pslverr_r;
    logic        pslverr_nxt;
    logic        fwd_valid_r;
    logic        fwd_valid_nxt;
    logic        fwd_hit_r;
    logic        fwd_hit_nxt;

    reg_sel_t    sel;
    logic        wr_take;
    word_t       wmask;
    word_t       img_io;
    word_t       img_mem;
    word_t       img_up;
    word_t       img_ctrl;
    word_t       new_io;
    word_t       new_mem;
    word_t       new_up;
    word_t       new_ctrl;
    word_t       rd_word;

    window_match_if win ();

    window_decode u_decode
    (
        .win (win.decoder)
    );

    // Current storage as register words, with fixed and reserved bits zero.
    always_comb
    begin
        img_io   = `WORD_ZERO;
        img_mem  = `WORD_ZERO;
        img_up   = `WORD_ZERO;
        img_ctrl = `WORD_ZERO;
        img_io[`IO_BASE_FLD]             = io_base_r;
        img_io[`IO_LIM_FLD]              = io_lim_r;
        img_mem[`MEM_BASE_FLD]           = mem_base_r;
        img_mem[`MEM_LIM_FLD]            = mem_lim_r;
        img_up[`IO_UP_BASE_FLD]          = io_up_base_r;
        img_up[`IO_UP_LIM_FLD]           = io_up_lim_r;
        img_ctrl[`CTRL_PERR_EN_BIT]      = perr_resp_en_r;
        img_ctrl[`CTRL_SYS_ERR_EN_BIT]   = system_error_report_enable_r;
    end

    // Read data as seen by software, including fixed fields and status.
    always_comb
    begin
        sel     = addr_decode(paddr);
        rd_word = `WORD_ZERO;
        unique case (sel)
            SEL_BUS_LAT:
            begin
                rd_word[`LAT_TIMER_FLD] = `LAT_TIMER_VAL;
            end
            SEL_IO_STS:
            begin
                rd_word = img_io;
                rd_word[`IO_BASE_IND_FLD]   = `IO_IND_VAL;
                rd_word[`IO_LIM_IND_FLD]    = `IO_IND_VAL;
                rd_word[`STS_PARITY_BIT]    = status_r[EVT_PARITY];
                rd_word[`STS_SIG_ABORT_BIT] = status_r[EVT_SIG_ABORT];
                rd_word[`STS_RX_ABORT_BIT]  = status_r[EVT_RX_ABORT];
                rd_word[`STS_RX_UR_BIT]     = status_r[EVT_RX_UR];
                rd_word[`STS_SYS_ERR_BIT]   = status_r[EVT_SYS_ERR];
                rd_word[`STS_POISON_BIT]    = status_r[EVT_POISON];
            end
            SEL_MEM_WIN: rd_word = img_mem;
            SEL_IO_UP:   rd_word = img_up;
            SEL_CTRL:    rd_word = img_ctrl;
            SEL_NONE:    rd_word = `WORD_ZERO;
        endcase
    end

    // APB answer: registered one cycle after setup, so every access has
    // exactly one access-phase cycle.
    always_comb
    begin
        pready_nxt  = psel && !penable;
        pslverr_nxt = psel && !penable && (sel == SEL_NONE);
        prdata_nxt  = (psel && !penable && !pwrite) ? rd_word : `WORD_ZERO;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= `WORD_ZERO;
        end
        else
        begin
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r  <= prdata_nxt;
        end
    end

    // Writes land at the completing edge of the access phase, byte by byte.
    always_comb
    begin
        wr_take  = psel && penable && pready_r && pwrite;
        wmask    = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
        new_io   = merge(img_io, pwdata, wmask);
        new_mem  = merge(img_mem, pwdata, wmask);
        new_up   = merge(img_up, pwdata, wmask);
        new_ctrl = merge(img_ctrl, pwdata, wmask);
        io_base_nxt    = io_base_r;
        io_lim_nxt     = io_lim_r;
        mem_base_nxt   = mem_base_r;
        mem_lim_nxt    = mem_lim_r;
        io_up_base_nxt = io_up_base_r;
        io_up_lim_nxt  = io_up_lim_r;
        perr_resp_en_nxt               = perr_resp_en_r;
        system_error_report_enable_nxt = system_error_report_enable_r;
        if (wr_take && sel == SEL_IO_STS)
        begin
            io_base_nxt = new_io[`IO_BASE_FLD];
            io_lim_nxt  = new_io[`IO_LIM_FLD];
        end
        if (wr_take && sel == SEL_MEM_WIN)
        begin
            mem_base_nxt = new_mem[`MEM_BASE_FLD];
            mem_lim_nxt  = new_mem[`MEM_LIM_FLD];
        end
        if (wr_take && sel == SEL_IO_UP)
        begin
            io_up_base_nxt = new_up[`IO_UP_BASE_FLD];
            io_up_lim_nxt  = new_up[`IO_UP_LIM_FLD];
        end
        if (wr_take && sel == SEL_CTRL)
        begin
            perr_resp_en_nxt               = new_ctrl[`CTRL_PERR_EN_BIT];
            system_error_report_enable_nxt = new_ctrl[`CTRL_SYS_ERR_EN_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            io_base_r    <= `IO_FLD_RST;
            io_lim_r     <= `IO_FLD_RST;
            mem_base_r   <= `MEM_FLD_RST;
            mem_lim_r    <= `MEM_FLD_RST;
            io_up_base_r <= `IO_UP_RST;
            io_up_lim_r  <= `IO_UP_RST;
            perr_resp_en_r               <= 1'b0;
            system_error_report_enable_r <= 1'b0;
        end
        else
        begin
            io_base_r    <= io_base_nxt;
            io_lim_r     <= io_lim_nxt;
            mem_base_r   <= mem_base_nxt;
            mem_lim_r    <= mem_lim_nxt;
            io_up_base_r <= io_up_base_nxt;
            io_up_lim_r  <= io_up_lim_nxt;
            perr_resp_en_r               <= perr_resp_en_nxt;
            system_error_report_enable_r <= system_error_report_enable_nxt;
        end
    end

    // Event sources and software clears for the sticky status bits.
    always_comb
    begin
        evt_set[EVT_PARITY]    = parity_err_evt && perr_resp_en_r;
        evt_set[EVT_SIG_ABORT] = cpl_abort_sent_evt;
        evt_set[EVT_RX_ABORT]  = rx_cpl_abort_evt;
        evt_set[EVT_RX_UR]     = rx_cpl_ur_evt;
        evt_set[EVT_SYS_ERR]   = err_msg_sent_evt && system_error_report_enable_r;
        evt_set[EVT_POISON]    = poisoned_rx_evt;
        evt_clr = {pwdata[`STS_POISON_BIT], pwdata[`STS_SYS_ERR_BIT],
                   pwdata[`STS_RX_UR_BIT], pwdata[`STS_RX_ABORT_BIT],
                   pwdata[`STS_SIG_ABORT_BIT], pwdata[`STS_PARITY_BIT]}
                  & `STS_W1C_MASK
                  & {6{wr_take && (sel == SEL_IO_STS) && pstrb[3]}};
    end

    // Each status bit: a new event wins over a clear in the same cycle.
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++)
        begin : g_status
            assign status_nxt[gi] = evt_set[gi] || (status_r[gi] && !evt_clr[gi]);
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_r <= `STS_RST;
        end
        else
        begin
            status_r <= status_nxt;
        end
    end

    // Window bounds widened with their implied low bits for the decoder.
    always_comb
    begin
        win.io_lo  = {io_up_base_r, io_base_r, `IO_LOW_ZERO};
        win.io_hi  = {io_up_lim_r, io_lim_r, `IO_LOW_ONES};
        win.mem_lo = {mem_base_r, `MEM_LOW_ZERO};
        win.mem_hi = {mem_lim_r, `MEM_LOW_ONES};
        win.addr   = fwd_addr;
        win.is_io  = fwd_is_io;
        fwd_valid_nxt = fwd_req;
        fwd_hit_nxt   = fwd_req && win.hit;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fwd_valid_r <= 1'b0;
            fwd_hit_r   <= 1'b0;
        end
        else
        begin
            fwd_valid_r <= fwd_valid_nxt;
            fwd_hit_r   <= fwd_hit_nxt;
        end
    end

    // Outputs come straight from flip-flops.
    assign prdata    = prdata_r;
    assign pready    = pready_r;
    assign pslverr   = pslverr_r;
    assign fwd_valid = fwd_valid_r;
    assign fwd_hit   = fwd_hit_r;

endmodule : bridge_secondary_window_regs

`default_nettype wire

// *** window_regs_checker.sv ***
/*
 * Concurrent checks on the ports of the downstream window register bank.
 * Assumes the bank answers every APB transfer with zero wait states.
 */
`timescale 1ns/1ps
`default_nettype none
`include "bridge_window_params.svh"

module window_regs_checker
(
    input wire logic                         pclk,
    input wire logic                         presetn,
    input wire logic                         psel,
    input wire logic                         penable,
    input wire logic                         pwrite,
    input wire bridge_window_pkg::apb_addr_t paddr,
    input wire bridge_window_pkg::word_t     prdata,
    input wire logic                         pready,
    input wire logic                         pslverr,
    input wire logic                         rx_cpl_abort_evt,
    input wire logic                         poisoned_rx_evt,
    input wire logic                         fwd_req,
    input wire logic                         fwd_valid,
    input wire logic                         fwd_hit
);
    import bridge_window_pkg::*;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Read answer and the setup of a status word read.
    logic rd_ack;
    assign rd_ack = pready && !pwrite;
    sequence s_sts_rd;
        psel && !penable && !pwrite && paddr == `OFS_IO_STS;
    endsequence

    // Handshake timing and idle levels.
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_idle_rdata_zero: assert property (!pready |-> prdata == `WORD_ZERO)
        else $error("prdata not zero when idle");
    a_slverr_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr outside an answer");

    // Fixed fields of the read words.
    a_lat_reads_zero: assert property (rd_ack && paddr == `OFS_BUS_LAT |-> prdata == 0)
        else $error("latency word not zero");
    a_io_nibbles_one: assert property (rd_ack && paddr == `OFS_IO_STS
        |-> prdata[3:0] == 4'h1 && prdata[11:8] == 4'h1)
        else $error("io indicator nibbles wrong");
    a_sts_zero_bits: assert property (rd_ack && paddr == `OFS_IO_STS
        |-> prdata[23:16] == 8'h00 && prdata[26:25] == 2'h0)
        else $error("inapplicable status bits set");
    a_mem_low_zero: assert property (rd_ack && paddr == `OFS_MEM_WIN
        |-> prdata[3:0] == 4'h0 && prdata[19:16] == 4'h0)
        else $error("memory reserved bits set");

    // Sticky events show in the next status read.
    a_poison_latch: assert property (poisoned_rx_evt ##1 s_sts_rd |=> prdata[31])
        else $error("poison event not latched");
    a_abort_latch: assert property (rx_cpl_abort_evt ##1 s_sts_rd |=> prdata[28])
        else $error("received abort not latched");

    // Forwarding answer timing.
    a_fwd_follows_req: assert property (fwd_req |=> fwd_valid)
        else $error("fwd_valid missing");
    a_hit_needs_valid: assert property (fwd_hit |-> fwd_valid)
        else $error("fwd_hit without fwd_valid");
endmodule : window_regs_checker

bind bridge_secondary_window_regs window_regs_checker i_chk
(
    .pclk             (pclk),
    .presetn          (presetn),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .rx_cpl_abort_evt (rx_cpl_abort_evt),
    .poisoned_rx_evt  (poisoned_rx_evt),
    .fwd_req          (fwd_req),
    .fwd_valid        (fwd_valid),
    .fwd_hit          (fwd_hit)
);

`default_nettype wire

// *** tb_top.sv ***
/*
 * Self-checking bench for the downstream window register bank.
 * Assumes the bank is the only APB slave and events come on pclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "bridge_window_params.svh"

module tb_top;
    import bridge_window_pkg::*;

    logic      pclk = 1'b0;
    logic      presetn, psel, penable, pwrite, pready, pslverr;
    apb_addr_t paddr;
    word_t     pwdata, prdata, fwd_addr, rd;
    byte_en_t  pstrb;
    logic [5:0] evt;
    logic      fwd_req, fwd_is_io, fwd_valid, fwd_hit, err;
    int        bad_count = 0;
    int        check_count = 0;

    bridge_secondary_window_regs i_dut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .parity_err_evt(evt[0]), .cpl_abort_sent_evt(evt[1]), .rx_cpl_abort_evt(evt[2]),
        .rx_cpl_ur_evt(evt[3]), .err_msg_sent_evt(evt[4]), .poisoned_rx_evt(evt[5]),
        .fwd_req(fwd_req), .fwd_addr(fwd_addr), .fwd_is_io(fwd_is_io),
        .fwd_valid(fwd_valid), .fwd_hit(fwd_hit)
    );

    // Clock at 100 MHz.
    always #5 pclk = ~pclk;

    // Compares one value and counts the outcome.
    task automatic check(input string name, input word_t seen, input word_t exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One APB transfer; holds the request until pready is sampled high.
    task automatic apb(input logic wr, input apb_addr_t a, input word_t d,
                       input byte_en_t s, output word_t q, output logic e);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // Each pass looks at the values settled just before a rising edge.
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        check("pready", pready, 1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input apb_addr_t a, input word_t d, input byte_en_t s);
        apb(1'b1, a, d, s, rd, err);
    endtask : wr

    task automatic rdchk(input apb_addr_t a, input word_t exp, input logic experr);
        apb(1'b0, a, 32'h0000_0000, 4'h0, rd, err);
        check("read data", rd, exp);
        check("pslverr", err, experr);
    endtask : rdchk

    // Raises the chosen event lines for one cycle and reads the status word
    // whose setup is sampled in the very next cycle.
    task automatic pulse_read(input logic [5:0] v, input word_t exp);
        fork
            begin
                @(posedge pclk);
                evt <= v;
                @(posedge pclk);
                evt <= 6'h00;
            end
            begin
                @(posedge pclk);
                rdchk(`OFS_IO_STS, exp, 0);
            end
        join
    endtask : pulse_read

    // Reset values of every mapped word.
    task automatic t_reset;
        rdchk(`OFS_BUS_LAT, 32'h0000_0000, 0);
        rdchk(`OFS_IO_STS, 32'h0000_0101, 0);
        rdchk(`OFS_MEM_WIN, 32'h0000_0000, 0);
        rdchk(`OFS_IO_UPPER, 32'h0000_0000, 0);
        rdchk(`OFS_EVT_CTRL, 32'h0000_0000, 0);
        $display("test reset values done");
    endtask : t_reset

    // Writable, fixed and unmapped places, with byte strobes.
    task automatic t_fields;
        wr(`OFS_BUS_LAT, 32'hffff_ffff, 4'hf);
        rdchk(`OFS_BUS_LAT, 32'h0000_0000, 0);
        wr(`OFS_IO_STS, 32'hffff_ffff, 4'h3);
        rdchk(`OFS_IO_STS, 32'h0000_f1f1, 0);
        wr(`OFS_MEM_WIN, 32'hffff_ffff, 4'hf);
        rdchk(`OFS_MEM_WIN, 32'hfff0_fff0, 0);
        wr(`OFS_IO_UPPER, 32'hffff_ffff, 4'hf);
        wr(`OFS_IO_UPPER, 32'h0000_0000, 4'h1);
        rdchk(`OFS_IO_UPPER, 32'hffff_ff00, 0);
        apb(1'b1, 12'h024, 32'hffff_ffff, 4'hf, rd, err);
        check("write pslverr", err, 1);
        rdchk(12'h024, 32'h0000_0000, 1);
        $display("test fields done");
    endtask : t_fields

    // Sticky status, enables and write-one-to-clear.
    task automatic t_events;
        wr(`OFS_EVT_CTRL, 32'h0000_0000, 4'hf);
        pulse_read(6'h11, 32'h0000_f1f1);
        wr(`OFS_EVT_CTRL, 32'h0000_0003, 4'hf);
        pulse_read(6'h3f, 32'hf900_f1f1);
        wr(`OFS_IO_STS, 32'h4000_f1f1, 4'hf);
        rdchk(`OFS_IO_STS, 32'hb900_f1f1, 0);
        wr(`OFS_IO_STS, 32'hffff_f1f1, 4'hf);
        rdchk(`OFS_IO_STS, 32'h3800_f1f1, 0);
        $display("test events done");
    endtask : t_events

    // Back-to-back window queries at both edges of each window.
    task automatic t_forward;
        word_t qa[8] = '{32'h0001_3000, 32'h0001_2fff, 32'h0002_5fff, 32'h0002_6000,
                         32'h1230_0000, 32'h122f_ffff, 32'h124f_ffff, 32'h1250_0000};
        logic  qh[8] = '{1, 0, 1, 0, 1, 0, 1, 0};
        wr(`OFS_IO_UPPER, 32'h0002_0001, 4'hf);
        wr(`OFS_IO_STS, 32'h0000_5131, 4'h3);
        wr(`OFS_MEM_WIN, 32'h1240_1230, 4'hf);
        for (int i = 0; i < 9; i++)
        begin
            @(posedge pclk);
            fwd_req   <= (i < 8);
            fwd_addr  <= qa[i % 8];
            fwd_is_io <= (i < 4);
            #1;
            if (i > 0)
            begin
                check("fwd_valid", fwd_valid, 1);
                check("fwd_hit", fwd_hit, qh[i - 1]);
            end
        end
        @(posedge pclk);
        #1;
        check("idle fwd_valid", fwd_valid, 0);
        check("idle fwd_hit", fwd_hit, 0);
        $display("test forward done");
    endtask : t_forward

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish

    // Main sequence.
    initial
    begin
        presetn   = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 12'h000;
        pwdata    = 32'h0000_0000;
        pstrb     = 4'h0;
        evt       = 6'h00;
        fwd_req   = 1'b0;
        fwd_addr  = 32'h0000_0000;
        fwd_is_io = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_fields();
        t_events();
        t_forward();
        tally_and_finish();
    end

    // Watchdog well beyond the hundred or so cycles the tests need.
    initial
    begin
        #100_000;
        bad_count++;
        tally_and_finish();
    end
endmodule : tb_top

`default_nettype wire
